/* File: core/sepc_core.sv */
// pin-level control of a serial eeprom slave
`default_nettype none
// Summary of operation
// R1: respond only while select is low
// R2: select high means deselected and standby
// R3: started programming always runs to completion
// R4: standby deferred until programming finishes
// R5: output floats at once on deselect
// R6: select rising after valid write starts programming
// R7: ignore sequences until select seen low
// R8: sample input on serial clock rising edge
// R9: change output after serial clock falling edge
// R10: protect pin low and enable refuse status
// R11: protect pin high allows everything
// R12: low protect pin cancels status write
// R13: protect pin cannot abort started write
// R14: enable bit clear ignores protect pin
// R15: pause low suspends and keeps sequence
// R16: pause taken only with clock low
// R17: master keeps select low while paused
// R18: paused pins float and are ignored
// R19: resume only with clock low
// R20: master keeps pause high when unused
// R21: commit only if select rises at byte boundary
// R22: completed write clears write enable latch
// R23: programming is configurable busy interval
module sepc_core
  import sepc_pkg::*;
#(
  parameter int unsigned PROG_LEN = PROG_CYCLES
) (
  // clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  // serial pins
  input wire logic i_sel_n,
  input wire logic i_sclk,
  input wire logic i_sdi,
  output logic o_sdo,
  output logic o_sdo_oe,
  input wire logic i_prot_n,
  input wire logic i_pause_n,
  // read data in; status flags and received write bytes out
  input wire logic [7:0] i_rd_data,
  output logic o_standby,
  output logic o_busy,
  output logic o_write_enable_latch,
  output logic o_protect_pin_enable_bit,
  output logic o_paused,
  output logic o_prog_start,
  output logic [7:0] o_wr_byte,
  output logic o_wr_byte_vld
);
  sepc_pins_type pins;
  // ==========================================================
  // synchronisers
  sepc_sync #(.RESET_VAL(1'b1)) u_sync_sel (
    .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_ce(i_ce),
    .i_pin(i_sel_n), .o_level(pins.sel_n));
  sepc_sync #(.RESET_VAL(1'b0)) u_sync_sclk (
    .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_ce(i_ce),
    .i_pin(i_sclk), .o_level(pins.sclk));
  sepc_sync #(.RESET_VAL(1'b0)) u_sync_sdi (
    .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_ce(i_ce),
    .i_pin(i_sdi), .o_level(pins.sdi));
  sepc_sync #(.RESET_VAL(1'b1)) u_sync_prot (
    .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_ce(i_ce),
    .i_pin(i_prot_n), .o_level(pins.prot_n));
  sepc_sync #(.RESET_VAL(1'b1)) u_sync_pause (
    .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_ce(i_ce),
    .i_pin(i_pause_n), .o_level(pins.pause_n));

  // ==========================================================
  // edges and selection state
  logic sclk_d_reg;
  logic sel_n_d_reg;
  logic armed_reg;
  logic paused_reg;
  logic sclk_rise;
  logic sclk_fall;
  logic sel_rise;
  logic selected;
  logic active;
  logic prog_busy;
  logic prog_done;
  logic start_prog;

  assign sclk_rise = pins.sclk & ~sclk_d_reg;
  assign sclk_fall = ~pins.sclk & sclk_d_reg;
  assign sel_rise = pins.sel_n & ~sel_n_d_reg;
  assign selected = ~pins.sel_n & armed_reg; // R1 R7
  assign active = selected & ~paused_reg; // R18

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      sclk_d_reg <= 1'b0;
      sel_n_d_reg <= 1'b1;
    end else if (i_ce) begin
      sclk_d_reg <= pins.sclk;
      sel_n_d_reg <= pins.sel_n;
    end
  end

  // power-up: a low select must be seen first
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      armed_reg <= 1'b0;
    end else if (i_ce && pins.sel_n && !sel_n_d_reg) begin
      armed_reg <= 1'b1; // R7
    end else if (i_ce && !pins.sel_n && !armed_reg && sel_n_d_reg) begin
      armed_reg <= 1'b0;
    end
  end
  // a select already low at release does not arm; the master must raise it first

  // ==========================================================
  // pause: entered and resumed only while serial clock is low; deselect clears it at any clock level
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      paused_reg <= 1'b0;
    end else if (i_ce) begin
      if (!selected) begin
        paused_reg <= 1'b0;
      end else if (!paused_reg && !pins.pause_n) begin
        if (!pins.sclk) begin
          paused_reg <= 1'b1; // R15 R16
        end
      end else if (paused_reg && pins.pause_n && !pins.sclk) begin
        paused_reg <= 1'b0; // R19
      end
    end
  end
  // with clock high the pause waits for the clock to fall, which the
  // low-clock test above catches in the same cycle that sclk_fall is seen

  // ==========================================================
  // serial receive
  logic [7:0] shift_reg;
  logic [2:0] bit_cnt_reg;
  logic [3:0] byte_cnt_reg;
  logic [7:0] opcode_reg;
  logic boundary_reg;
  logic data_seen_reg;
  logic [7:0] wr_byte_reg;
  logic wr_byte_vld_reg;
  logic [7:0] rx_next;

  assign rx_next = {shift_reg[6:0], pins.sdi};

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      shift_reg <= '0;
      bit_cnt_reg <= BIT_CNT_ZERO;
      byte_cnt_reg <= '0;
      opcode_reg <= '0;
      boundary_reg <= 1'b0;
      data_seen_reg <= 1'b0;
      wr_byte_reg <= '0;
      wr_byte_vld_reg <= 1'b0;
    end else if (i_ce) begin
      wr_byte_vld_reg <= 1'b0;
      if (!selected) begin
        bit_cnt_reg <= BIT_CNT_ZERO;
        byte_cnt_reg <= '0;
        boundary_reg <= 1'b0;
        data_seen_reg <= 1'b0;
      end else if (active && sclk_rise) begin
        shift_reg <= rx_next; // R8
        bit_cnt_reg <= bit_cnt_reg + 1'b1;
        boundary_reg <= (bit_cnt_reg == BIT_CNT_LAST); // R21
        if (bit_cnt_reg == BIT_CNT_LAST) begin
          if (byte_cnt_reg == '0) begin
            opcode_reg <= rx_next;
          end else if (byte_cnt_reg > ADDR_BYTES ||
                       opcode_reg == OP_WR_STATUS) begin
            data_seen_reg <= 1'b1;
            wr_byte_reg <= rx_next;
            wr_byte_vld_reg <= 1'b1;
          end
          if (byte_cnt_reg != 4'hf) begin
            byte_cnt_reg <= byte_cnt_reg + 1'b1;
          end
        end
      end
    end
  end

  // ==========================================================
  // write launch and protection
  logic wel_reg;
  logic ppe_reg;
  logic pend_ppe_reg;
  logic sr_blocked_reg;
  logic valid_wr;
  logic hw_protect;

  assign hw_protect = ppe_reg & ~pins.prot_n; // R10 R11 R14
  assign valid_wr = boundary_reg & data_seen_reg & wel_reg & ~prog_busy; // R21 R23
  assign start_prog = sel_rise & armed_reg & valid_wr & (opcode_reg == OP_WR_ARRAY ||
                      (opcode_reg == OP_WR_STATUS && !sr_blocked_reg)); // R6 R12

  // with the enable bit set, a low protect pin at any point after the instruction byte of a status sequence cancels it
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      sr_blocked_reg <= 1'b0;
    end else if (i_ce) begin
      if (!selected) begin
        sr_blocked_reg <= 1'b0;
      end else if (hw_protect && opcode_reg == OP_WR_STATUS && byte_cnt_reg != '0) begin
        sr_blocked_reg <= 1'b1; // R12
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      wel_reg <= 1'b0;
    end else if (i_ce) begin
      if (prog_done) begin
        wel_reg <= 1'b0; // R22
      end else if (sel_rise && armed_reg && boundary_reg && byte_cnt_reg == 4'h1 &&
                   !prog_busy) begin
        if (opcode_reg == OP_SET_LATCH) begin
          wel_reg <= 1'b1;
        end else if (opcode_reg == OP_CLR_LATCH) begin
          wel_reg <= 1'b0;
        end
      end
    end
  end

  // the enable bit changes only when its own status write completes
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      ppe_reg <= 1'b0;
      pend_ppe_reg <= 1'b0;
    end else if (i_ce) begin
      if (start_prog && opcode_reg == OP_WR_STATUS) begin
        pend_ppe_reg <= 1'b1;
        ppe_reg <= ppe_reg;
      end
      if (start_prog && opcode_reg == OP_WR_STATUS) begin
        pend_ppe_reg <= wr_byte_reg[SR_PROT_BIT];
      end else if (prog_done) begin
        ppe_reg <= pend_ppe_reg; // R13
      end
    end
  end

  sepc_prog_timer #(.CYCLES(PROG_LEN)) u_timer (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_start(start_prog), // R3 R23
    .o_busy(prog_busy),
    .o_done(prog_done)
  );

  // ==========================================================
  // serial transmit
  logic [7:0] tx_reg;
  logic sdo_reg;
  logic sdo_oe_reg;
  logic reading;

  assign reading = (opcode_reg == OP_RD_STATUS) ||
                   (opcode_reg == OP_RD_ARRAY && byte_cnt_reg > ADDR_BYTES);

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      tx_reg <= '0;
      sdo_reg <= 1'b0;
    end else if (i_ce && active && sclk_fall && reading && byte_cnt_reg != '0) begin
      if (bit_cnt_reg == BIT_CNT_ZERO) begin
        sdo_reg <= i_rd_data[7]; // R9
        tx_reg <= {i_rd_data[6:0], 1'b0};
      end else begin
        sdo_reg <= tx_reg[7]; // R9
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
    end
  end

  // driver floats as soon as a high select, or a low pause with the clock low, is seen
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      sdo_oe_reg <= 1'b0;
    end else if (i_ce) begin
      sdo_oe_reg <= active && reading && byte_cnt_reg != '0 &&
                    !(pins.sel_n) && !(!pins.pause_n && !pins.sclk); // R5 R18
    end
  end

  // ==========================================================
  // status outputs
  logic standby_reg;
  logic paused_out_reg;
  logic prog_start_reg;
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      standby_reg <= 1'b1;
      paused_out_reg <= 1'b0;
      prog_start_reg <= 1'b0;
    end else if (i_ce) begin
      standby_reg <= pins.sel_n & ~prog_busy & ~start_prog; // R2 R4
      paused_out_reg <= paused_reg;
      prog_start_reg <= start_prog;
    end
  end

  assign o_sdo = sdo_reg;
  assign o_sdo_oe = sdo_oe_reg;
  assign o_standby = standby_reg;
  assign o_busy = prog_busy;
  assign o_write_enable_latch = wel_reg;
  assign o_protect_pin_enable_bit = ppe_reg;
  assign o_paused = paused_out_reg;
  assign o_prog_start = prog_start_reg;
  assign o_wr_byte = wr_byte_reg;
  assign o_wr_byte_vld = wr_byte_vld_reg;

  // ==========================================================
  // checks
  sequence s_launch;
    start_prog ##1 prog_busy;
  endsequence
  AST_NO_STANDBY_BUSY: assert property (@(posedge i_sys_clk) disable iff (i_srst) // R4
    prog_busy |-> ##1 !standby_reg) else $error("standby while programming");
  AST_FLOAT_DESEL: assert property (@(posedge i_sys_clk) disable iff (i_srst) // R5
    (i_ce && pins.sel_n) |=> !sdo_oe_reg) else $error("output driven deselected");
  AST_LAUNCH: assert property (@(posedge i_sys_clk) disable iff (i_srst) // R6
    (i_ce && start_prog) |=> prog_busy) else $error("launch missed");
  AST_WEL_CLEAR: assert property (@(posedge i_sys_clk) disable iff (i_srst) // R22
    (i_ce && prog_done) |=> !wel_reg) else $error("latch not cleared");
  AST_ARMED: assert property (@(posedge i_sys_clk) disable iff (i_srst) // R7
    !armed_reg |-> !start_prog) else $error("launch before arming");
  AST_PROT: assert property (@(posedge i_sys_clk) disable iff (i_srst) // R12
    (sr_blocked_reg && opcode_reg == OP_WR_STATUS) |-> !start_prog)
    else $error("protected status write launched");
  AST_BUSY_HOLD: assert property (@(posedge i_sys_clk) disable iff (i_srst) // R3
    (i_ce and s_launch) |-> ##1 (prog_busy || prog_done)) else $error("cycle aborted");
  AST_PAUSE_QUIET: assert property (@(posedge i_sys_clk) disable iff (i_srst) // R18
    paused_reg |=> $stable(shift_reg)) else $error("shift while paused");
endmodule : sepc_core
`default_nettype wire

/* File: core/sepc_pkg.sv */
// package for the serial eeprom pin-control block
`default_nettype none
package sepc_pkg;
  // ==========================================================
  // timing
  localparam int unsigned SYS_CLK_HZ = 10_000_000;
  localparam int unsigned PROG_TIME_US = 5000;
  localparam int unsigned PROG_CYCLES = (PROG_TIME_US * (SYS_CLK_HZ / 1_000_000));
  localparam int unsigned SYNC_STAGES = 3;
  // ==========================================================
  // byte framing
  localparam int unsigned BYTE_BITS = 8;
  localparam logic [2:0] BIT_CNT_LAST = 3'h7;
  localparam logic [2:0] BIT_CNT_ZERO = 3'h0;
  // ==========================================================
  // instruction codes
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_RD_STATUS = 8'h05;
  localparam logic [7:0] OP_WR_STATUS = 8'h01;
  localparam logic [7:0] OP_RD_ARRAY = 8'h03;
  localparam logic [7:0] OP_WR_ARRAY = 8'h02;
  // ==========================================================
  // sequence phases, in bytes after the instruction, and the status protect bit
  localparam logic [3:0] ADDR_BYTES = 4'h2;
  localparam int unsigned SR_PROT_BIT = 7;
  // ==========================================================
  // synchronised pin bundle and write kinds
  typedef struct packed {
    logic sel_n;
    logic sclk;
    logic sdi;
    logic prot_n;
    logic pause_n;
  } sepc_pins_type;
  typedef enum logic [1:0] {
    WR_NONE,
    WR_ARRAY,
    WR_STATUS
  } sepc_wr_kind_type;
endpackage : sepc_pkg
`default_nettype wire

/* File: core/sepc_sync.sv */
// three-stage pin synchroniser with agreement check
`default_nettype none
module sepc_sync
  import sepc_pkg::*;
#(
  parameter logic RESET_VAL = 1'b1
) (
  // clock and control
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  // pin
  input wire logic i_pin,
  output logic o_level
);
  logic meta_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;
  // ==========================================================
  // first stage only feeds the second
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      meta_reg <= RESET_VAL;
      s2_reg <= RESET_VAL;
      s3_reg <= RESET_VAL;
    end else if (i_ce) begin
      meta_reg <= i_pin;
      s2_reg <= meta_reg;
      s3_reg <= s2_reg;
    end
  end
  // change counts once stages two and three agree
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      level_reg <= RESET_VAL;
    end else if (i_ce && (s2_reg == s3_reg)) begin
      level_reg <= s3_reg;
    end
  end
  assign o_level = level_reg;
endmodule : sepc_sync
`default_nettype wire

/* File: core/sepc_prog_timer.sv */
// self-timed programming interval counter
`default_nettype none
module sepc_prog_timer
  import sepc_pkg::*;
#(
  parameter int unsigned CYCLES = PROG_CYCLES
) (
  // clock and control
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  // start and status
  input wire logic i_start,
  output logic o_busy,
  output logic o_done
);
  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);
  logic [CW-1:0] cnt_reg;
  logic busy_reg;
  logic done_reg;
  // ==========================================================
  // once started the count ignores every pin
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      cnt_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (i_ce) begin
      done_reg <= 1'b0;
      if (busy_reg) begin
        if (cnt_reg == '0) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - 1'b1;
        end
      end else if (i_start) begin
        busy_reg <= 1'b1;
        cnt_reg <= LOAD;
      end
    end
  end
  assign o_busy = busy_reg;
  assign o_done = done_reg;
endmodule : sepc_prog_timer
`default_nettype wire

/* File: test/sepc_master.sv */
// spi bus master model that drives the eeprom pins
`default_nettype none
module sepc_master (
  // clock
  input wire logic i_sys_clk,
  // bus pins
  output logic o_sel_n,
  output logic o_sclk,
  output logic o_sdi,
  output logic o_pause_n,
  input wire logic i_sdo
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // idle levels
  initial begin
    o_sel_n = 1'b1;
    o_sclk = 1'b0;
    o_sdi = 1'b0;
    o_pause_n = 1'b1;
  end
  // ==========================================
  // link timing
  // half period of the 800 ns link clock, always just after a system edge
  task automatic half();
    repeat (4) @(posedge i_sys_clk);
    #1;
  endtask : half
  task automatic sel(input logic v);
    o_sel_n = v;
    // a released data line must not keep showing the last bit
    if (v) o_sdi = ~o_sdi;
    half();
  endtask : sel
  // mode 0: data set while clock low, output read just before the fall
  task automatic bit_x(input logic b, output logic q);
    o_sdi = b;
    half();
    o_sclk = 1'b1;
    half();
    q = i_sdo;
    o_sclk = 1'b0;
  endtask : bit_x
  task automatic byte_x(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
  endtask : byte_x
  // pause changes only with the clock low and select held low
  task automatic pause(input logic v);
    half();
    o_pause_n = v;
    half();
    half();
  endtask : pause
endmodule : sepc_master
`default_nettype wire

/* File: test/test_sepc_core.sv */
// self-checking testbench for the eeprom pin-control block
`default_nettype none
module test_sepc_core;
  import sepc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // short programming interval keeps the run brief
  localparam int unsigned PLEN = 20;
  logic i_sys_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_prot_n = 1'b1;
  logic i_ce = 1'b1;
  logic [7:0] i_rd_data = 8'h3c;
  logic sel_n, sclk, sdi, pause_n, miso;
  logic o_sdo, o_sdo_oe, o_standby, o_busy, o_wel, o_pen, o_paused, o_prog_start, o_wr_byte_vld;
  logic [7:0] o_wr_byte, q;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  int n_vld = 0;
  // ==========================================
  // clock, wire and instances
  always #50 i_sys_clk = ~i_sys_clk;
  // undriven output line shows the inverse of its last value
  assign miso = o_sdo_oe ? o_sdo : ~o_sdo;
  sepc_master u_mst (.i_sys_clk(i_sys_clk), .o_sel_n(sel_n), .o_sclk(sclk), .o_sdi(sdi),
    .o_pause_n(pause_n), .i_sdo(miso));
  sepc_core #(.PROG_LEN(PLEN)) DUT (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_ce(i_ce),
    .i_sel_n(sel_n), .i_sclk(sclk), .i_sdi(sdi), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe),
    .i_prot_n(i_prot_n), .i_pause_n(pause_n), .i_rd_data(i_rd_data), .o_standby(o_standby),
    .o_busy(o_busy), .o_write_enable_latch(o_wel), .o_protect_pin_enable_bit(o_pen),
    .o_paused(o_paused), .o_prog_start(o_prog_start), .o_wr_byte(o_wr_byte),
    .o_wr_byte_vld(o_wr_byte_vld));
  // ==========================================
  // helpers
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      test_done();
    end
  end
  // data-byte pulses, seen one edge after they are launched
  always @(posedge i_sys_clk) begin
    n_vld += (o_wr_byte_vld === 1'b1);
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chkb(input logic got, input logic exp);
    chk({7'h0, got}, {7'h0, exp});
  endtask : chkb
  task automatic settle();
    repeat (6) @(posedge i_sys_clk);
    #1;
  endtask : settle
  task automatic frame(input logic [7:0] op, input logic a, input logic w, input logic [7:0] d);
    u_mst.sel(1'b0);
    u_mst.byte_x(op, q);
    if (a) u_mst.byte_x(8'h00, q);
    if (a) u_mst.byte_x(8'h10, q);
    if (w) u_mst.byte_x(d, q);
  endtask : frame
  task automatic wren();
    frame(OP_SET_LATCH, 1'b0, 1'b0, 8'h00);
    chkb(o_standby, 1'b0);
    u_mst.sel(1'b1);
    settle();
    chkb(o_wel, 1'b1);
  endtask : wren
  // watch a programming interval after select has risen
  task automatic prog(input logic e);
    int st, bz, bad;
    st = 0;
    bz = 0;
    bad = 0;
    repeat (80) begin
      @(posedge i_sys_clk);
      #1;
      st += (o_prog_start === 1'b1);
      bz += (o_busy === 1'b1);
      bad += (o_busy === 1'b1 && o_standby === 1'b1);
    end
    chk(8'(st), {7'h0, e});
    chk(8'(bz), e ? 8'(PLEN) : 8'h00);
    chk(8'(bad), 8'h00);
    chkb(o_standby, 1'b1);
  endtask : prog
  task automatic wr_array(input logic [7:0] d);
    wren();
    n_vld = 0;
    frame(OP_WR_ARRAY, 1'b1, 1'b1, d);
    // the last bit needs five system edges to reach the byte register
    u_mst.sel(1'b1);
    chk(o_wr_byte, d);
    chk(8'(n_vld), 8'h01);
    // select dips low mid-programming, which must not cut it short
    fork
      prog(1'b1);
      begin
        repeat (6) @(posedge i_sys_clk);
        #1;
        u_mst.sel(1'b0);
        u_mst.sel(1'b1);
      end
    join
    chkb(o_wel, 1'b0);
  endtask : wr_array
  task automatic wrsr(input logic p, input logic [7:0] d, input logic f, input logic e,
    input logic pen);
    i_prot_n = p;
    wren();
    frame(OP_WR_STATUS, 1'b0, 1'b1, d);
    u_mst.sel(1'b1);
    fork
      prog(e);
      begin
        repeat (8) @(posedge i_sys_clk);
        #1;
        if (f) i_prot_n = 1'b0;
      end
    join
    chkb(o_pen, pen);
  endtask : wrsr
  // ==========================================
  // scenarios
  task automatic t_arm();
    settle();
    chkb(o_standby, 1'b1);
    chkb(o_sdo_oe, 1'b0);
    chkb(o_wel, 1'b0);
    frame(OP_SET_LATCH, 1'b0, 1'b0, 8'h00);
    u_mst.sel(1'b1);
    settle();
    chkb(o_wel, 1'b0);
    u_mst.byte_x(OP_SET_LATCH, q);
    settle();
    chkb(o_wel, 1'b0);
    wren();
  endtask : t_arm
  task automatic t_abort();
    logic b;
    wren();
    frame(OP_WR_ARRAY, 1'b1, 1'b0, 8'h00);
    for (int i = 0; i < 4; i++) u_mst.bit_x(1'b1, b);
    u_mst.sel(1'b1);
    prog(1'b0);
    chkb(o_wel, 1'b1);
    frame(OP_CLR_LATCH, 1'b0, 1'b0, 8'h00);
    u_mst.sel(1'b1);
    settle();
    chkb(o_wel, 1'b0);
  endtask : t_abort
  task automatic t_read();
    for (int i = 0; i < 2; i++) begin
      i_rd_data = (i == 0) ? 8'h3c : 8'hc3;
      frame((i == 0) ? OP_RD_ARRAY : OP_RD_STATUS, i == 0, 1'b0, 8'h00);
      u_mst.byte_x(8'h00, q);
      chk(q, i_rd_data);
      chkb(o_sdo_oe, 1'b1);
      u_mst.sel(1'b1);
      repeat (2) @(posedge i_sys_clk);
      #1;
      chkb(o_sdo_oe, 1'b0);
    end
  endtask : t_read
  task automatic t_prot();
    wrsr(1'b1, 8'h80, 1'b1, 1'b1, 1'b1);
    wrsr(1'b0, 8'h00, 1'b0, 1'b0, 1'b1);
    wr_array(8'h5a);
    wrsr(1'b1, 8'h00, 1'b0, 1'b1, 1'b0);
    wrsr(1'b0, 8'h80, 1'b0, 1'b1, 1'b1);
    i_prot_n = 1'b1;
  endtask : t_prot
  task automatic t_pause();
    logic b;
    wren();
    frame(OP_WR_ARRAY, 1'b1, 1'b0, 8'h00);
    for (int i = 3; i >= 0; i--) u_mst.bit_x(i[0] ^ i[1] ^ 1'b1, b);
    u_mst.pause(1'b0);
    chkb(o_paused, 1'b1);
    chkb(o_sdo_oe, 1'b0);
    // toggling while paused must leave the half-received byte untouched
    for (int i = 0; i < 4; i++) u_mst.bit_x(1'b0, b);
    u_mst.pause(1'b1);
    chkb(o_paused, 1'b0);
    for (int i = 3; i >= 0; i--) u_mst.bit_x(i[0], b);
    u_mst.sel(1'b1);
    chk(o_wr_byte, 8'h9a);
    prog(1'b1);
  endtask : t_pause
  // a frozen block ignores a whole latch-set frame
  task automatic t_freeze();
    i_ce = 1'b0;
    frame(OP_SET_LATCH, 1'b0, 1'b0, 8'h00);
    chkb(o_standby, 1'b1);
    u_mst.sel(1'b1);
    settle();
    i_ce = 1'b1;
    settle();
    chkb(o_wel, 1'b0);
    wren();
  endtask : t_freeze
  // ==========================================
  // main sequence
  initial begin
    repeat (4) @(posedge i_sys_clk);
    #1;
    i_srst = 1'b0;
    t_arm();
    wr_array(8'ha5);
    t_abort();
    t_read();
    t_prot();
    t_pause();
    t_freeze();
    test_done();
  end
endmodule : test_sepc_core
`default_nettype wire
